//--- rtl/hlt_pkg.sv
// Constants, register map and carrier types for the hardware-limit timer
package hlt_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [9:0]  HLT_IDX_COUNT   = 10'h28C;
    localparam logic [9:0]  HLT_IDX_PERIOD  = 10'h28D;
    localparam logic [9:0]  HLT_IDX_CTRL    = 10'h28E;
    localparam logic [9:0]  HLT_IDX_LIMIT   = 10'h28F;
    localparam logic [9:0]  HLT_IDX_CLKSEL  = 10'h290;
    localparam logic [9:0]  HLT_IDX_RSTSEL  = 10'h291;
    localparam int          HLT_ADDR_W      = 12;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  HLT_RST_COUNT   = 8'h00;
    localparam logic [7:0]  HLT_RST_PERIOD  = 8'hFF;
    localparam logic [7:0]  HLT_RST_CTRL    = 8'h00;
    localparam logic [7:0]  HLT_RST_LIMIT   = 8'h00;
    localparam logic [2:0]  HLT_RST_CLKSEL  = 3'h0;
    localparam logic [3:0]  HLT_RST_RSTSEL  = 4'h0;

    // ------------------------------------------------------------------
    // Control mode codes
    // ------------------------------------------------------------------
    localparam logic [4:0]  HLT_MODE_RISE_RST  = 5'h03;
    localparam logic [4:0]  HLT_MODE_FALL_RST  = 5'h04;
    localparam logic [4:0]  HLT_MODE_ANY_RST   = 5'h05;
    localparam logic [4:0]  HLT_MODE_LOW_RST   = 5'h06;
    localparam logic [4:0]  HLT_MODE_HIGH_RST  = 5'h07;
    localparam logic [4:0]  HLT_MODE_ONE_SHOT  = 5'h08;

    // ------------------------------------------------------------------
    // Clock source and external reset source codes
    // ------------------------------------------------------------------
    localparam logic [2:0]  HLT_CS_PIN      = 3'h0;
    localparam logic [2:0]  HLT_CS_INSTR    = 3'h1;
    localparam logic [2:0]  HLT_CS_SYS      = 3'h2;
    localparam logic [2:0]  HLT_CS_HF_OSC   = 3'h3;
    localparam logic [2:0]  HLT_CS_LF_OSC   = 3'h4;
    localparam logic [2:0]  HLT_CS_MF_500K  = 3'h5;
    localparam logic [2:0]  HLT_CS_MF_32K   = 3'h6;
    localparam logic [3:0]  HLT_RS_PIN      = 4'h0;
    localparam logic [3:0]  HLT_RS_CMP_ONE  = 4'h1;
    localparam logic [3:0]  HLT_RS_CMP_TWO  = 4'h2;
    localparam logic [3:0]  HLT_RS_PWM_THR  = 4'h3;
    localparam logic [3:0]  HLT_RS_PWM_FOUR = 4'h4;

    // ------------------------------------------------------------------
    // Timing and bus answers
    // ------------------------------------------------------------------
    localparam logic [1:0]  HLT_INSTR_LAST  = 2'h3;
    localparam logic [1:0]  HLT_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  HLT_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic       on;
        logic [2:0] clock_prescale;
        logic [3:0] output_postscale;
    } hlt_ctrl_s;

    typedef struct packed {
        logic       prescaler_sync;
        logic       clock_edge_polarity;
        logic       run_bit_sync;
        logic [4:0] mode;
    } hlt_limit_s;

endpackage : hlt_pkg

//--- rtl/hlt_timer.sv
// Hardware-limit 8-bit period timer with AXI4-Lite register slave
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

module hlt_timer (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic [hlt_pkg::HLT_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output      logic                          s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output      logic                          s_axi_wready,
    output      logic [1:0]                    s_axi_bresp,
    output      logic                          s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [hlt_pkg::HLT_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output      logic                          s_axi_arready,
    output      logic [31:0]                   s_axi_rdata,
    output      logic [1:0]                    s_axi_rresp,
    output      logic                          s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic                          sleep,
    input  wire logic                          input_pin_route,
    input  wire logic                          high_freq_internal_osc,
    input  wire logic                          low_freq_internal_osc,
    input  wire logic                          mid_freq_osc_500k,
    input  wire logic                          mid_freq_osc_32k,
    input  wire logic                          reset_pin_route,
    input  wire logic                          compare_output_one,
    input  wire logic                          compare_output_two,
    input  wire logic                          pulse_width_output_three,
    input  wire logic                          pulse_width_output_four,
    output      logic                          period_match,
    output      logic                          timer_event,
    output      logic                          timer_running,
    output      logic [2:0]                    osc_keep_alive
);
    import hlt_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]  count_q;
    logic [7:0]  period_q;
    hlt_ctrl_s   ctrl_q;
    hlt_limit_s  limit_q;
    logic [2:0]  clksel_q;
    logic [3:0]  rstsel_q;

    logic [5:0]  sync1_q;
    logic [5:0]  sync2_q;
    logic [5:0]  async_in;
    logic        clk_lvl_prev_q;
    logic        ers_prev_q;
    logic [1:0]  instr_div_q;
    logic [1:0]  run_sync_q;
    logic [6:0]  pre_q;
    logic [3:0]  post_q;
    logic        match_q;
    logic        event_q;
    logic        running_q;
    logic [2:0]  keep_q;

    logic        aw_held_q;
    logic        w_held_q;
    logic [9:0]  aw_idx_q;
    logic [7:0]  wdata_q;
    logic        wlane_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    assign async_in = {reset_pin_route, mid_freq_osc_32k, mid_freq_osc_500k,
                       low_freq_internal_osc, high_freq_internal_osc,
                       input_pin_route};

    for (genvar i = 0; i < 6; i++) begin : g_sync
        always_ff @(posedge clock) begin
            if (rst) begin
                sync1_q[i] <= 1'b0;
                sync2_q[i] <= 1'b0;
            end else begin
                sync1_q[i] <= async_in[i];
                sync2_q[i] <= sync1_q[i];
            end
        end
    end

    // ------------------------------------------------------------------
    // Timer clock selection
    // ------------------------------------------------------------------
    logic clk_lvl;
    logic clk_is_lvl;
    logic in_tick;
    logic freeze;
    logic edge_seen;

    always_comb begin
        clk_lvl    = 1'b0;
        clk_is_lvl = 1'b1;
        case (clksel_q)
            HLT_CS_PIN:     clk_lvl = sync2_q[0];
            HLT_CS_HF_OSC:  clk_lvl = sync2_q[1];
            HLT_CS_LF_OSC:  clk_lvl = sync2_q[2];
            HLT_CS_MF_500K: clk_lvl = sync2_q[3];
            HLT_CS_MF_32K:  clk_lvl = sync2_q[4];
            default:        clk_is_lvl = 1'b0;
        endcase
    end

    // Polarity picks the edge that counts
    assign edge_seen = limit_q.clock_edge_polarity ? (clk_lvl_prev_q & ~clk_lvl)
                                    : (~clk_lvl_prev_q & clk_lvl);

    // Core clock stops in sleep; sync'd prescaler freezes outright
    assign freeze = sleep & limit_q.prescaler_sync;

    always_comb begin
        in_tick = 1'b0;
        if (clk_is_lvl) begin
            in_tick = edge_seen;
        end else if (clksel_q == HLT_CS_INSTR) begin
            in_tick = (instr_div_q == HLT_INSTR_LAST) & ~sleep;
        end else if (clksel_q == HLT_CS_SYS) begin
            in_tick = ~sleep;
        end
        if (freeze) begin
            in_tick = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            clk_lvl_prev_q <= 1'b0;
            instr_div_q    <= 2'h0;
        end else begin
            clk_lvl_prev_q <= clk_lvl;
            instr_div_q    <= instr_div_q + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // External reset source and mode decode
    // ------------------------------------------------------------------
    logic ers_lvl;
    logic ers_clr;

    always_comb begin
        case (rstsel_q)
            HLT_RS_PIN:      ers_lvl = sync2_q[5];
            HLT_RS_CMP_ONE:  ers_lvl = compare_output_one;
            HLT_RS_CMP_TWO:  ers_lvl = compare_output_two;
            HLT_RS_PWM_THR:  ers_lvl = pulse_width_output_three;
            HLT_RS_PWM_FOUR: ers_lvl = pulse_width_output_four;
            default:         ers_lvl = 1'b0;
        endcase
    end

    always_comb begin
        case (limit_q.mode)
            HLT_MODE_RISE_RST: ers_clr = ers_lvl & ~ers_prev_q;
            HLT_MODE_FALL_RST: ers_clr = ~ers_lvl & ers_prev_q;
            HLT_MODE_ANY_RST:  ers_clr = ers_lvl ^ ers_prev_q;
            HLT_MODE_LOW_RST:  ers_clr = ~ers_lvl;
            HLT_MODE_HIGH_RST: ers_clr = ers_lvl;
            default:           ers_clr = 1'b0;
        endcase
        if (freeze) begin
            ers_clr = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ers_prev_q <= 1'b0;
        end else begin
            ers_prev_q <= ers_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Run control, prescaler, postscaler
    // ------------------------------------------------------------------
    logic       run_en;
    logic [6:0] pre_lim;
    logic       pre_tick;
    logic       count_hit;
    logic       period_evt;
    logic       post_last;
    logic       cnt_wr;
    logic       ctrl_wr;

    // Sync'd start waits two input clocks; stop is always immediate
    assign run_en   = ctrl_q.on & (~limit_q.run_bit_sync | run_sync_q[1]);
    assign pre_lim  = 7'((8'h01 << ctrl_q.clock_prescale) - 8'h01);
    assign pre_tick = in_tick & run_en & (pre_q == pre_lim);
    assign count_hit  = (count_q == period_q);
    assign period_evt = pre_tick & count_hit;
    assign post_last  = (post_q == ctrl_q.output_postscale);

    always_ff @(posedge clock) begin
        if (rst || !ctrl_q.on) begin
            run_sync_q <= 2'h0;
        end else if (in_tick) begin
            run_sync_q <= {run_sync_q[0], 1'b1};
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !ctrl_q.on) begin
            pre_q <= 7'h00;
        end else if (in_tick && run_en) begin
            pre_q <= (pre_q == pre_lim) ? 7'h00 : pre_q + 7'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !ctrl_q.on) begin
            post_q  <= 4'h0;
            event_q <= 1'b0;
        end else begin
            event_q <= period_evt & post_last;
            if (period_evt) begin
                post_q <= post_last ? 4'h0 : post_q + 4'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            match_q   <= 1'b0;
            running_q <= 1'b0;
            keep_q    <= 3'h0;
        end else begin
            match_q   <= period_evt;
            running_q <= run_en;
            keep_q    <= {(clksel_q == HLT_CS_MF_500K) ||
                          (clksel_q == HLT_CS_MF_32K),
                          clksel_q == HLT_CS_LF_OSC,
                          clksel_q == HLT_CS_HF_OSC};
        end
    end

    // ------------------------------------------------------------------
    // Counter: bus write, then external reset, then prescaled tick
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            count_q <= HLT_RST_COUNT;
        end else if (cnt_wr) begin
            count_q <= wdata_q;
        end else if (ers_clr) begin
            count_q <= 8'h00;
        end else if (pre_tick) begin
            count_q <= count_hit ? 8'h00 : 8'(count_q + 8'h01);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    logic wr_do;
    logic wr_map;

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready  = ~w_held_q & ~bvalid_q;
    assign wr_do   = aw_held_q & w_held_q;
    assign wr_map  = (aw_idx_q >= HLT_IDX_COUNT) &&
                     (aw_idx_q <= HLT_IDX_RSTSEL);
    assign cnt_wr  = wr_do & wlane_q & (aw_idx_q == HLT_IDX_COUNT);
    assign ctrl_wr = wr_do & wlane_q & (aw_idx_q == HLT_IDX_CTRL);

    always_ff @(posedge clock) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            aw_idx_q  <= 10'h000;
        end else if (wr_do) begin
            aw_held_q <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_idx_q  <= s_axi_awaddr[HLT_ADDR_W-1:2];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            w_held_q <= 1'b0;
            wdata_q  <= 8'h00;
            wlane_q  <= 1'b0;
        end else if (wr_do) begin
            w_held_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= HLT_RESP_OKAY;
        end else if (wr_do) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_map ? HLT_RESP_OKAY : HLT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Software write of the run bit wins over a hardware clear
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_q <= hlt_ctrl_s'(HLT_RST_CTRL);
        end else if (ctrl_wr) begin
            ctrl_q <= hlt_ctrl_s'(wdata_q);
        end else if (period_evt &&
                     limit_q.mode == HLT_MODE_ONE_SHOT) begin
            ctrl_q.on <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            period_q <= HLT_RST_PERIOD;
            limit_q  <= hlt_limit_s'(HLT_RST_LIMIT);
            clksel_q <= HLT_RST_CLKSEL;
            rstsel_q <= HLT_RST_RSTSEL;
        end else if (wr_do && wlane_q) begin
            case (aw_idx_q)
                HLT_IDX_PERIOD: period_q <= wdata_q;
                HLT_IDX_LIMIT:  limit_q  <= hlt_limit_s'(wdata_q);
                HLT_IDX_CLKSEL: clksel_q <= wdata_q[2:0];
                HLT_IDX_RSTSEL: rstsel_q <= wdata_q[3:0];
                default:        ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    logic [9:0] ar_idx;
    logic [7:0] rd_val;
    logic       rd_map;

    assign ar_idx        = s_axi_araddr[HLT_ADDR_W-1:2];
    assign s_axi_arready = ~rvalid_q;

    always_comb begin
        rd_val = 8'h00;
        rd_map = 1'b1;
        case (ar_idx)
            HLT_IDX_COUNT:  rd_val = count_q;
            HLT_IDX_PERIOD: rd_val = period_q;
            HLT_IDX_CTRL:   rd_val = ctrl_q;
            HLT_IDX_LIMIT:  rd_val = limit_q;
            HLT_IDX_CLKSEL: rd_val = {5'h00, clksel_q};
            HLT_IDX_RSTSEL: rd_val = {4'h0, rstsel_q};
            default:        rd_map = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= HLT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_val};
            rresp_q  <= rd_map ? HLT_RESP_OKAY : HLT_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid   = bvalid_q;
    assign s_axi_bresp    = bresp_q;
    assign s_axi_rvalid   = rvalid_q;
    assign s_axi_rdata    = rdata_q;
    assign s_axi_rresp    = rresp_q;
    assign period_match   = match_q;
    assign timer_event    = event_q;
    assign timer_running  = running_q;
    assign osc_keep_alive = keep_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_sleep_freeze;
        @(posedge clock) disable iff (rst)
        (sleep && limit_q.prescaler_sync && !cnt_wr) |=> $stable(count_q);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze)
        else $error("counter moved in sleep with prescaler sync");

    property p_match_clear;
        @(posedge clock) disable iff (rst)
        (pre_tick && count_hit && !cnt_wr) |=> (count_q == 8'h00);
    endproperty
    a_match_clear: assert property (p_match_clear)
        else $error("period match did not clear counter");

    property p_count_up;
        @(posedge clock) disable iff (rst)
        (pre_tick && !count_hit && !cnt_wr && !ers_clr)
            |=> (count_q == 8'($past(count_q) + 8'h01));
    endproperty
    a_count_up: assert property (p_count_up)
        else $error("counter did not advance by one");

    property p_off_resets;
        @(posedge clock) disable iff (rst)
        !ctrl_q.on |=> (pre_q == 7'h00) && (post_q == 4'h0);
    endproperty
    a_off_resets: assert property (p_off_resets)
        else $error("prescaler or postscaler not reset when off");

    property p_one_shot;
        @(posedge clock) disable iff (rst)
        (period_evt && limit_q.mode == HLT_MODE_ONE_SHOT && !ctrl_wr)
            |=> !ctrl_q.on ##1 !timer_running;
    endproperty
    a_one_shot: assert property (p_one_shot)
        else $error("one-shot match left timer on");

    property p_prescale;
        @(posedge clock) disable iff (rst)
        pre_tick |-> in_tick && (pre_q == pre_lim);
    endproperty
    a_prescale: assert property (p_prescale)
        else $error("prescaler tick at wrong count");

    property p_postscale;
        @(posedge clock) disable iff (rst)
        (ctrl_q.on && !ctrl_wr) |->
            ((period_evt && post_last) ##1 timer_event) or
            (!(period_evt && post_last) ##1 !timer_event);
    endproperty
    a_postscale: assert property (p_postscale)
        else $error("postscaled event mismatch");

    property p_sync_start;
        @(posedge clock) disable iff (rst)
        (limit_q.run_bit_sync && $rose(ctrl_q.on)) |-> !run_en ##1 !run_en;
    endproperty
    a_sync_start: assert property (p_sync_start)
        else $error("synchronised start came too early");

    property p_stop_keeps;
        @(posedge clock) disable iff (rst)
        (!ctrl_q.on && !cnt_wr && !ers_clr)
            |-> !pre_tick ##1 $stable(count_q);
    endproperty
    a_stop_keeps: assert property (p_stop_keeps)
        else $error("stopped timer changed its count");

    c_one_shot: cover property (@(posedge clock) disable iff (rst)
        period_evt && limit_q.mode == HLT_MODE_ONE_SHOT);
    c_post_event: cover property (@(posedge clock) disable iff (rst)
        timer_event && ctrl_q.output_postscale != 4'h0);
    c_sleep_run: cover property (@(posedge clock) disable iff (rst)
        sleep && !limit_q.prescaler_sync && pre_tick);
    c_bus_write: cover property (@(posedge clock) disable iff (rst)
        bvalid_q && s_axi_bready);

endmodule : hlt_timer

//--- sim/testbench.sv
// Self-checking bench for the hardware-limit timer register block
`timescale 1ns/1ps

module testbench;
    import hlt_pkg::*;
    logic clock = 0, rst = 1, sleep = 0, cmp1 = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, tm, te, run;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] keep;
    logic [7:0] osc = 0;
    logic [33:0] exp_q[$];
    int fail_count = 0, checks = 0, n, p, o, k;

    hlt_timer uut (.clock(clock), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sleep(sleep), .input_pin_route(osc[3]),
        .high_freq_internal_osc(osc[1]), .low_freq_internal_osc(osc[4]),
        .mid_freq_osc_500k(osc[2]), .mid_freq_osc_32k(osc[5]),
        .reset_pin_route(osc[6]), .compare_output_one(cmp1),
        .compare_output_two(osc[3]), .pulse_width_output_three(osc[4]),
        .pulse_width_output_four(osc[5]), .period_match(tm),
        .timer_event(te), .timer_running(run), .osc_keep_alive(keep));

    initial forever #12.5 clock = ~clock;
    // Slow free-running levels stand in for oscillators and pins
    always @(posedge clock) osc <= osc + 8'h01;

    task automatic end_of_test;
        if (fail_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    always @(posedge clock) if (rvalid === 1'b1 && rready === 1'b1)
        chk({rresp, rdata}, exp_q.pop_front());
    always @(posedge clock) if (bvalid === 1'b1 && bready === 1'b1)
        chk({bresp, 32'h0}, exp_q.pop_front());

    task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        exp_q.push_back({er, 32'h0});
        @(posedge clock);
        awaddr <= {idx, 2'b00}; awvalid <= 1; wdata <= {24'h0, d};
        wstrb <= 4'hF; wvalid <= 1; bready <= 1;
        for (n = 0; n < 1000; n++) begin
            @(posedge clock);
            if (awready === 1'b1) awvalid <= 0;
            if (wready === 1'b1) wvalid <= 0;
            if (bvalid === 1'b1) break;
        end
        if (n == 1000) begin fail_count++; end_of_test(); end
        bready <= 0;
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        exp_q.push_back({er, 24'h0, d});
        @(posedge clock);
        araddr <= {idx, 2'b00}; arvalid <= 1; rready <= 1;
        for (n = 0; n < 1000; n++) begin
            @(posedge clock);
            if (arready === 1'b1) arvalid <= 0;
            if (rvalid === 1'b1) break;
        end
        if (n == 1000) begin fail_count++; end_of_test(); end
        rready <= 0;
    endtask : rd

    // Counts edges up to and including the next pulse
    task automatic waitp(input int sel, output int c);
        for (c = 1; c < 5000; c++) begin
            @(posedge clock);
            if ((sel ? te : tm) === 1'b1) break;
        end
        if (c == 5000) begin fail_count++; end_of_test(); end
    endtask : waitp

    initial begin
        void'($urandom(34));
        repeat (5) @(posedge clock);
        rst <= 0;
        // ----------------------------------------------------------
        // Reset values, unmapped place
        // ----------------------------------------------------------
        rd(HLT_IDX_COUNT, 8'h00, HLT_RESP_OKAY);
        rd(HLT_IDX_PERIOD, 8'hFF, HLT_RESP_OKAY);
        rd(HLT_IDX_CTRL, 8'h00, HLT_RESP_OKAY);
        rd(HLT_IDX_LIMIT, 8'h00, HLT_RESP_OKAY);
        rd(HLT_IDX_RSTSEL, 8'h00, HLT_RESP_OKAY);
        rd(10'h292, 8'h00, HLT_RESP_SLVERR);
        wr(10'h292, 8'h5A, HLT_RESP_SLVERR);
        wr(HLT_IDX_COUNT, 8'h10, HLT_RESP_OKAY);
        rd(HLT_IDX_COUNT, 8'h10, HLT_RESP_OKAY);
        // ----------------------------------------------------------
        // Period, every prescale code, postscale
        // ----------------------------------------------------------
        p = $urandom_range(6, 1);
        o = $urandom_range(15, 0);
        wr(HLT_IDX_PERIOD, p[7:0], HLT_RESP_OKAY);
        wr(HLT_IDX_CLKSEL, {5'h0, HLT_CS_SYS}, HLT_RESP_OKAY);
        for (k = 0; k < 8; k++) begin
            wr(HLT_IDX_CTRL, {1'b1, k[2:0], 4'h0}, HLT_RESP_OKAY);
            waitp(0, n);
            waitp(0, n);
            chk(n, (p + 1) << k);
        end
        wr(HLT_IDX_CTRL, {4'h8, o[3:0]}, HLT_RESP_OKAY);
        waitp(1, n);
        waitp(1, n);
        chk(n, (p + 1) * (o + 1));
        // ----------------------------------------------------------
        // One-shot, external level reset, sleep freeze
        // ----------------------------------------------------------
        wr(HLT_IDX_CTRL, 8'h00, HLT_RESP_OKAY);
        wr(HLT_IDX_LIMIT, {3'h0, HLT_MODE_ONE_SHOT}, HLT_RESP_OKAY);
        wr(HLT_IDX_CTRL, 8'h80, HLT_RESP_OKAY);
        waitp(0, n);
        repeat (3) @(posedge clock);
        chk(run, 1'b0);
        rd(HLT_IDX_CTRL, 8'h00, HLT_RESP_OKAY);
        wr(HLT_IDX_LIMIT, {3'h0, HLT_MODE_HIGH_RST}, HLT_RESP_OKAY);
        wr(HLT_IDX_RSTSEL, {4'h0, HLT_RS_CMP_ONE}, HLT_RESP_OKAY);
        cmp1 <= 1;
        wr(HLT_IDX_CTRL, 8'h80, HLT_RESP_OKAY);
        repeat (20) @(posedge clock);
        rd(HLT_IDX_COUNT, 8'h00, HLT_RESP_OKAY);
        cmp1 <= 0;
        wr(HLT_IDX_LIMIT, {3'h0, HLT_MODE_LOW_RST}, HLT_RESP_OKAY);
        repeat (20) @(posedge clock);
        rd(HLT_IDX_COUNT, 8'h00, HLT_RESP_OKAY);
        wr(HLT_IDX_CTRL, 8'h00, HLT_RESP_OKAY);
        wr(HLT_IDX_LIMIT, 8'h80, HLT_RESP_OKAY);
        wr(HLT_IDX_CLKSEL, {5'h0, HLT_CS_HF_OSC}, HLT_RESP_OKAY);
        // Keep-alive flag lags the select write by one cycle
        @(posedge clock);
        chk(keep, 3'b001);
        sleep <= 1;
        wr(HLT_IDX_COUNT, 8'h05, HLT_RESP_OKAY);
        wr(HLT_IDX_CTRL, 8'h80, HLT_RESP_OKAY);
        repeat (40) @(posedge clock);
        rd(HLT_IDX_COUNT, 8'h05, HLT_RESP_OKAY);
        rd(HLT_IDX_PERIOD, p[7:0], HLT_RESP_OKAY);
        // Unsynced prescaler keeps counting in sleep off a level source
        wr(HLT_IDX_CTRL, 8'h00, HLT_RESP_OKAY);
        wr(HLT_IDX_LIMIT, 8'h60, HLT_RESP_OKAY);
        wr(HLT_IDX_CTRL, 8'h80, HLT_RESP_OKAY);
        waitp(0, n);
        waitp(0, n);
        chk(n, (p + 1) * 4);
        sleep <= 0;
        repeat (2) @(posedge clock);
        end_of_test();
    end
endmodule : testbench
